// [test/nvc_host_asserts.sv]
/* Concurrent checks on the host controller pins and command port.
   Bound to nvc_host; sees only its ports, one clock domain. */
`timescale 1ns/1ns
`default_nettype none

module nvc_host_asserts #(
    parameter int STORE_CYCLES = 50
)
(
    // watched ports
    input wire logic clk,
    input wire logic rstn,
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_op,
    input wire logic cmd_ready,
    input wire logic rsp_valid,
    input wire logic [nvc_pkg::ADDR_W-1:0] address_lines,
    input wire logic chip_enable_n,
    input wire logic write_enable_n,
    input wire logic output_enable_n,
    input wire logic data_lines_oe,
    input wire logic store_busy_n_oe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence s_take_rd;
        cmd_valid && cmd_ready && cmd_op == 3'h0;
    endsequence
    sequence s_take_wr;
        cmd_valid && cmd_ready && cmd_op == 3'h1;
    endsequence

    property p_we_in_ce;
        !write_enable_n |-> !chip_enable_n;
    endproperty
    a_we_in_ce: assert property (p_we_in_ce)
        else $error("write enable low while deselected");
    property p_oe_off_write;
        !write_enable_n |-> output_enable_n && data_lines_oe;
    endproperty
    a_oe_off_write: assert property (p_oe_off_write)
        else $error("write without driven data or with output enable low");
    property p_no_fight;
        data_lines_oe |-> output_enable_n;
    endproperty
    a_no_fight: assert property (p_no_fight)
        else $error("host drives data while output enable low");
    property p_addr_hold;
        !chip_enable_n && $past(!chip_enable_n) |-> $stable(address_lines);
    endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("address moved while selected");
    property p_ce_pulse;
        $fell(chip_enable_n) |-> !chip_enable_n [*3];
    endproperty
    a_ce_pulse: assert property (p_ce_pulse)
        else $error("select pulse shorter than three cycles");
    property p_rd_lat;
        s_take_rd |=> !rsp_valid [*6] ##[1:5] rsp_valid;
    endproperty
    a_rd_lat: assert property (p_rd_lat)
        else $error("read answer out of window");
    property p_wr_lat;
        s_take_wr |=> !rsp_valid [*5] ##[1:4] rsp_valid;
    endproperty
    a_wr_lat: assert property (p_wr_lat)
        else $error("write answer out of window");
    property p_take;
        cmd_valid && cmd_ready && cmd_op <= 3'h4 |=> !cmd_ready;
    endproperty
    a_take: assert property (p_take)
        else $error("ready stayed high after take");
    property p_rsp;
        rsp_valid |-> cmd_ready ##1 !rsp_valid;
    endproperty
    a_rsp: assert property (p_rsp)
        else $error("response not a single pulse with ready");
    property p_pin_pulse;
        $rose(store_busy_n_oe) |-> store_busy_n_oe [*8];
    endproperty
    a_pin_pulse: assert property (p_pin_pulse)
        else $error("store request pulse too short");
endmodule : nvc_host_asserts

bind nvc_host nvc_host_asserts #(.STORE_CYCLES(STORE_CYCLES)) u_asserts (.clk(clk), .rstn(rstn),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .address_lines(address_lines), .chip_enable_n(chip_enable_n), .write_enable_n(write_enable_n),
    .output_enable_n(output_enable_n), .data_lines_oe(data_lines_oe), .store_busy_n_oe(store_busy_n_oe));

`default_nettype wire

// [test/nvc_host_bench.sv]
/* Self-checking bench: host controller against the memory model.
   Assumes the bound checker and a reduced store count. */
`timescale 1ns/1ns
`default_nettype none

module nvc_host_bench;
    import nvc_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic cmd_valid = 1'b0;
    logic [2:0] cmd_op = 3'h0;
    logic [ADDR_W-1:0] cmd_addr = '0;
    logic [DATA_W-1:0] cmd_wdata = '0;
    logic cmd_ready, rsp_valid, ce_n, we_n, oe_n, h_doe, d_doe, h_bout, h_boe, d_pull;
    logic [DATA_W-1:0] rsp_rdata, h_dout, d_dout, rd;
    logic [ADDR_W-1:0] addr;
    int fail_count = 0;
    int checks = 0;
    // line resolution, store/busy has a pull-up
    // a fight on the data lines lets the memory win, so a write breaks
    wire logic [DATA_W-1:0] dq = (h_doe && !d_doe) ? h_dout : d_dout;
    wire logic busy_line = !(h_boe && !h_bout) && !d_pull;

    always #10 clk = ~clk;

    nvc_host #(.STORE_CYCLES(50)) u_dut (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .address_lines(addr), .chip_enable_n(ce_n), .write_enable_n(we_n),
        .output_enable_n(oe_n), .data_lines_in(dq), .data_lines_out(h_dout), .data_lines_oe(h_doe),
        .store_busy_n_in(busy_line), .store_busy_n_out(h_bout), .store_busy_n_oe(h_boe));
    nvc_nvsram_model u_mem (.address_lines(addr), .chip_enable_n(ce_n), .write_enable_n(we_n),
        .output_enable_n(oe_n), .data_lines_in(dq), .data_lines_out(d_dout), .data_lines_oe(d_doe),
        .store_busy_n(busy_line), .store_busy_n_pull(d_pull));

    task automatic print_verdict();
        if (fail_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic cmd(input logic [2:0] op, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 4000)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        cmd_op = op;
        cmd_addr = a;
        cmd_wdata = d;
        cmd_valid = 1'b1;
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 4000)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(8'(n < 4000), 8'h01);
        rd = rsp_rdata;
    endtask : cmd

    task automatic t_power_up();
        cmd(OP_READ, 13'h0042, 8'h00);
        chk(rd, 8'h7E);
    endtask : t_power_up

    task automatic t_write_read();
        cmd(OP_WRITE, 13'h1FFF, 8'hA5);
        cmd(OP_WRITE, 13'h0000, 8'h5A);
        cmd(OP_READ, 13'h1FFF, 8'h00);
        chk(rd, 8'hA5);
        cmd(OP_READ, 13'h0000, 8'h00);
        chk(rd, 8'h5A);
    endtask : t_write_read

    task automatic t_sw_store_recall();
        cmd(OP_WRITE, 13'h0123, 8'hC3);
        cmd(OP_SW_STORE, 13'h0000, 8'h00);
        cmd(OP_WRITE, 13'h0123, 8'h3C);
        cmd(OP_READ, 13'h0123, 8'h00);
        chk(rd, 8'h3C);
        repeat (2)
        begin
            cmd(OP_SW_RECALL, 13'h0000, 8'h00);
            cmd(OP_READ, 13'h0123, 8'h00);
            chk(rd, 8'hC3);
        end
        cmd(OP_READ, 13'h1FFF, 8'h00);
        chk(rd, 8'hA5);
    endtask : t_sw_store_recall

    task automatic t_pin_store();
        cmd(OP_WRITE, 13'h0555, 8'h96);
        cmd(OP_HW_STORE, 13'h0000, 8'h00);
        cmd(OP_WRITE, 13'h0555, 8'h00);
        cmd(OP_SW_RECALL, 13'h0000, 8'h00);
        cmd(OP_READ, 13'h0555, 8'h00);
        chk(rd, 8'h96);
    endtask : t_pin_store

    task automatic t_supply();
        cmd(OP_WRITE, 13'h0321, 8'hE7);
        fork
            u_mem.supply_cycle(3000);
            begin
                repeat (40) @(posedge clk);
                #1;
                cmd(OP_WRITE, 13'h0321, 8'h18);
                cmd(OP_HW_STORE, 13'h0000, 8'h00);
            end
        join
        cmd(OP_READ, 13'h0321, 8'h00);
        chk(rd, 8'hE7);
    endtask : t_supply

    task automatic t_bad_op();
        int seen;
        seen = 0;
        cmd_op = 3'h5;
        cmd_valid = 1'b1;
        repeat (20)
        begin
            @(posedge clk);
            #1;
            seen += int'(rsp_valid === 1'b1 || cmd_ready !== 1'b1);
        end
        cmd_valid = 1'b0;
        chk(8'(seen), 8'h00);
    endtask : t_bad_op

    initial
    begin
        repeat (2) @(posedge clk);
        #1;
        rstn = 1'b1;
        t_power_up();
        t_write_read();
        t_sw_store_recall();
        t_pin_store();
        t_supply();
        t_bad_op();
        print_verdict();
    end

    initial
    begin
        #400000;
        fail_count++;
        print_verdict();
    end
endmodule : nvc_host_bench

`default_nettype wire

// [test/nvc_nvsram_model.sv]
/* Behavioural 8K x 8 memory with shadow cells, clockless.
   Assumes the bench resolves the data and store/busy lines. */
`timescale 1ns/1ns
`default_nettype none

module nvc_nvsram_model
    import nvc_pkg::*;
#(
    parameter int STORE_NS = 600,
    parameter int RECALL_NS = 2000
)
(
    // memory pins
    input wire logic [nvc_pkg::ADDR_W-1:0] address_lines,
    input wire logic chip_enable_n,
    input wire logic write_enable_n,
    input wire logic output_enable_n,
    input wire logic [nvc_pkg::DATA_W-1:0] data_lines_in,
    output logic [nvc_pkg::DATA_W-1:0] data_lines_out,
    output logic data_lines_oe,
    input wire logic store_busy_n,
    output logic store_busy_n_pull
);
    logic [DATA_W-1:0] sram [0:8191];
    logic [DATA_W-1:0] nv [0:8191];
    logic nv_mode, dirty, wr_cyc, rd_cyc;
    logic supply_low;
    int step;

    function automatic logic [ADDR_W-1:0] seq_addr(input int s);
        case (s)
            0: return SEQ_ADDR_0;
            1: return SEQ_ADDR_1;
            2: return SEQ_ADDR_2;
            3: return SEQ_ADDR_3;
            default: return SEQ_ADDR_4;
        endcase
    endfunction : seq_addr

    task do_store();
        nv_mode = 1'b1;
        store_busy_n_pull = 1'b1;
        for (int i = 0; i < 8192; i++)
            nv[i] = '1;
        #(STORE_NS);
        for (int i = 0; i < 8192; i++)
            nv[i] = sram[i];
        dirty = 1'b0;
        store_busy_n_pull = 1'b0;
        nv_mode = 1'b0;
    endtask : do_store

    task do_recall();
        nv_mode = 1'b1;
        for (int i = 0; i < 8192; i++)
            sram[i] = '0;
        #(RECALL_NS);
        for (int i = 0; i < 8192; i++)
            sram[i] = nv[i];
        nv_mode = 1'b0;
    endtask : do_recall

    // hold-up supply dip, started from the bench
    task automatic supply_cycle(input int low_ns);
        supply_low = 1'b1;
        if (dirty && !nv_mode)
            do_store();
        #(low_ns);
        supply_low = 1'b0;
        do_recall();
    endtask : supply_cycle

    // read drive, inverse pattern when released
    assign data_lines_oe = !chip_enable_n && !output_enable_n && write_enable_n && store_busy_n && !nv_mode;
    assign data_lines_out = data_lines_oe ? sram[address_lines] : ~sram[address_lines];

    always @(chip_enable_n or write_enable_n)
        if (!chip_enable_n && !nv_mode)
            if (!write_enable_n)
                wr_cyc = 1'b1;
            else
                rd_cyc = 1'b1;

    always @(posedge chip_enable_n or posedge write_enable_n)
    begin
        if (wr_cyc && store_busy_n && !nv_mode)
        begin
            sram[address_lines] = data_lines_in;
            dirty = 1'b1;
            step = 0;
        end
        else if (rd_cyc && chip_enable_n && !nv_mode)
        begin
            if (step == 5 && address_lines == SEQ_ADDR_STORE)
            begin
                step = 0;
                do_store();
            end
            else if (step == 5 && address_lines == SEQ_ADDR_RECALL)
            begin
                step = 0;
                do_recall();
            end
            else if (step < 5 && address_lines == seq_addr(step))
                step++;
            else
                step = (address_lines == SEQ_ADDR_0) ? 1 : 0;
        end
        wr_cyc = 1'b0;
        rd_cyc = 1'b0;
    end

    always @(negedge store_busy_n)
        if (!nv_mode && !store_busy_n_pull)
        begin
            if (dirty && !supply_low)
                do_store();
            nv_mode = 1'b1;
            wait (store_busy_n === 1'b1);
            nv_mode = 1'b0;
        end

    initial
    begin
        step = 0;
        wr_cyc = 1'b0;
        rd_cyc = 1'b0;
        dirty = 1'b0;
        supply_low = 1'b0;
        store_busy_n_pull = 1'b0;
        for (int i = 0; i < 8192; i++)
            nv[i] = DATA_W'(i) ^ 8'h3C;
        do_recall();
    end
endmodule : nvc_nvsram_model

`default_nettype wire

// [verilog/nvc_host.sv]
/*
 * Host-side controller for an 8K x 8 SRAM with nonvolatile shadow cells.
 * Drives address, chip enable, write enable, output enable, the data lines
 * and the open-drain store/busy line; offers read, write, software store,
 * software recall and pin store on a simple command port.
 * Assumes the pins are joined to the memory by the bench; inputs from the
 * pins are asynchronous and are synchronised here.
 */
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// R1: six reads ending 0F0F start store
// R2: same five, then 0F0E starts recall
// R3: nothing may interrupt the six reads
// R4: write enable high while chip enabled
// R5: each step clocked by a chip-enable pulse
// R6: device runs nonvolatile cycle alone, outputs off
// R7: store erases then programs nonvolatile cells
// R8: memory usable again after store time
// R9: recall clears then reloads memory, repeatable
// R10: read when enabled, output enabled, idle
// R11: read outputs follow address until deselect
// R12: write with enable low, address held stable
// R13: device floats outputs when write starts
// R14: host keeps output enable high writing
// R15: memory blocked during nonvolatile cycle
// R16: device stores on supply loss
// R17: device recalls at power-up and recovery
// R18: low hold-up supply inhibits external stores
// R19: short select pulse still counts as step
// R20: no chip-enable glitches during sequence
// R21: never write-state at power-up recall end
// R22: pin store runs only after a write
// R23: software store always runs
// R24: after pin store, blocked until line high
// R25: wrong address or write restarts sequence
module nvc_host
    import nvc_pkg::*;
#(
    parameter int STORE_CYCLES = nvc_pkg::STORE_CYCLES_DEF
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // command port
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_op,
    input wire logic [nvc_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [nvc_pkg::DATA_W-1:0] cmd_wdata,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [nvc_pkg::DATA_W-1:0] rsp_rdata,
    // memory pins
    output logic [nvc_pkg::ADDR_W-1:0] address_lines,
    output logic chip_enable_n,
    output logic write_enable_n,
    output logic output_enable_n,
    input wire logic [nvc_pkg::DATA_W-1:0] data_lines_in,
    output logic [nvc_pkg::DATA_W-1:0] data_lines_out,
    output logic data_lines_oe,
    input wire logic store_busy_n_in,
    output logic store_busy_n_out,
    output logic store_busy_n_oe
);

    import nvc_pkg::*;

    // ------------------------------------------------------------------
    // types and state
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_SETUP = 3'h1,
        ST_STROBE = 3'h3,
        ST_RELEASE = 3'h2,
        ST_NV_WAIT = 3'h6,
        ST_PIN_DRIVE = 3'h4,
        ST_PIN_REL = 3'h5
    } nvc_state_e;

    localparam logic [TMR_W-1:0] STORE_WAIT = TMR_W'(STORE_CYCLES);

    nvc_state_e state_r;
    nvc_op_e op_r;
    logic [STEP_W-1:0] step_r;
    logic pend_r;
    logic tmr_load_r;
    logic [TMR_W-1:0] tmr_val_r;
    logic tmr_expired;
    logic busy_s1_r;
    logic busy_s2_r;
    logic [DATA_W-1:0] data_s1_r;
    logic [DATA_W-1:0] data_s2_r;

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    wire is_read = (op_r == OP_READ);
    wire is_write = (op_r == OP_WRITE);
    wire is_seq = (op_r == OP_SW_STORE) || (op_r == OP_SW_RECALL);
    wire seq_done = (step_r == SEQ_LAST_STEP);
    wire line_high = busy_s2_r;
    wire [STEP_W-1:0] step_nxt = step_r + STEP_W'(1);
    wire [ADDR_W-1:0] final_addr = (op_r == OP_SW_STORE) ? SEQ_ADDR_STORE : SEQ_ADDR_RECALL;
    wire [ADDR_W-1:0] next_seq_addr =
        (step_nxt == 3'h1) ? SEQ_ADDR_1 :
        (step_nxt == 3'h2) ? SEQ_ADDR_2 :
        (step_nxt == 3'h3) ? SEQ_ADDR_3 :
        (step_nxt == 3'h4) ? SEQ_ADDR_4 : final_addr; // [R1] [R2]
    wire cmd_is_seq = (cmd_op == OP_SW_STORE) || (cmd_op == OP_SW_RECALL);
    wire cmd_legal = (cmd_op <= OP_HW_STORE);
    wire [TMR_W-1:0] pulse_len = is_read ? READ_CYCLES : (is_write ? WRITE_CYCLES : SEQ_PULSE_CYCLES);
    wire [TMR_W-1:0] nv_len = (op_r == OP_SW_STORE) ? STORE_WAIT : RECALL_CYCLES;

    // ------------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            busy_s1_r <= 1'b1;
            busy_s2_r <= 1'b1;
            data_s1_r <= '0;
            data_s2_r <= '0;
        end
        else
        begin
            busy_s1_r <= store_busy_n_in;
            busy_s2_r <= busy_s1_r;
            data_s1_r <= data_lines_in;
            data_s2_r <= data_s1_r;
        end
    end

    // ------------------------------------------------------------------
    // phase timer; reset value covers the power-up recall
    // ------------------------------------------------------------------
    nvc_timer #(
        .RESET_VAL(RECALL_CYCLES)
    ) u_timer (
        .clk(clk),
        .rstn(rstn),
        .load(tmr_load_r),
        .load_val(tmr_val_r),
        .expired(tmr_expired)
    );

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            state_r <= ST_NV_WAIT; // [R17] [R21]
            op_r <= OP_READ;
            step_r <= '0;
            pend_r <= 1'b0;
            tmr_load_r <= 1'b0;
            tmr_val_r <= '0;
            cmd_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
            address_lines <= '0;
            chip_enable_n <= 1'b1;
            write_enable_n <= 1'b1; // [R21]
            output_enable_n <= 1'b1;
            data_lines_out <= '0;
            data_lines_oe <= 1'b0;
            store_busy_n_out <= 1'b0;
            store_busy_n_oe <= 1'b0;
        end
        else
        begin
            tmr_load_r <= 1'b0;
            rsp_valid <= 1'b0;
            unique case (state_r)
                ST_IDLE:
                begin
                    if (cmd_valid && cmd_legal)
                    begin
                        op_r <= nvc_op_e'(cmd_op);
                        pend_r <= 1'b1;
                        cmd_ready <= 1'b0;
                        step_r <= '0;
                        address_lines <= cmd_is_seq ? SEQ_ADDR_0 : cmd_addr;
                        data_lines_out <= cmd_wdata;
                        tmr_load_r <= 1'b1;
                        if (cmd_op == OP_HW_STORE)
                        begin
                            tmr_val_r <= ASSERT_CYCLES;
                            store_busy_n_oe <= 1'b1; // [R22] [R24]
                            state_r <= ST_PIN_DRIVE;
                        end
                        else
                        begin
                            data_lines_oe <= (cmd_op == OP_WRITE);
                            state_r <= ST_SETUP;
                        end
                    end
                end
                ST_SETUP:
                begin
                    // address settled one cycle before select
                    chip_enable_n <= 1'b0; // [R5] [R10] [R12]
                    write_enable_n <= !is_write; // [R4]
                    output_enable_n <= !is_read; // [R14]
                    tmr_load_r <= 1'b1;
                    tmr_val_r <= pulse_len; // [R19]
                    state_r <= ST_STROBE;
                end
                ST_STROBE:
                begin
                    if (tmr_expired)
                    begin
                        // data captured by the memory on this rising edge
                        chip_enable_n <= 1'b1; // [R12] [R20]
                        write_enable_n <= 1'b1;
                        output_enable_n <= 1'b1;
                        if (is_read)
                            rsp_rdata <= data_s2_r; // [R11]
                        state_r <= ST_RELEASE;
                    end
                end
                ST_RELEASE:
                begin
                    data_lines_oe <= 1'b0;
                    if (is_seq && !seq_done)
                    begin
                        // steps follow back to back, no other access between
                        step_r <= step_nxt; // [R3] [R25]
                        address_lines <= next_seq_addr;
                        state_r <= ST_SETUP;
                    end
                    else if (is_seq)
                    begin
                        tmr_load_r <= 1'b1;
                        tmr_val_r <= nv_len; // [R6] [R7] [R9] [R23]
                        state_r <= ST_NV_WAIT;
                    end
                    else
                    begin
                        rsp_valid <= 1'b1;
                        pend_r <= 1'b0;
                        cmd_ready <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                end
                ST_NV_WAIT:
                begin
                    // memory stays deselected until the cycle ends
                    if (tmr_expired && line_high)
                    begin
                        rsp_valid <= pend_r; // [R8] [R15]
                        pend_r <= 1'b0;
                        cmd_ready <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                end
                ST_PIN_DRIVE:
                begin
                    if (tmr_expired)
                    begin
                        store_busy_n_oe <= 1'b0;
                        tmr_load_r <= 1'b1;
                        tmr_val_r <= RECOVER_CYCLES;
                        state_r <= ST_PIN_REL;
                    end
                end
                ST_PIN_REL:
                begin
                    // device holds the line low while it stores
                    if (tmr_expired && line_high)
                    begin
                        rsp_valid <= 1'b1; // [R24]
                        pend_r <= 1'b0;
                        cmd_ready <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                end
                default:
                begin
                    state_r <= ST_IDLE;
                    cmd_ready <= 1'b1;
                end
            endcase
        end
    end

endmodule : nvc_host

`default_nettype wire

// [verilog/nvc_pkg.sv]
/*
 * Constants shared by the nonvolatile SRAM host controller: pin widths,
 * unlock address sequence, command codes and timing counts.
 * Assumes a 50 MHz system clock.
 */
package nvc_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int TMR_W = 20;
    localparam int STEP_W = 3;

    // ------------------------------------------------------------------
    // software sequence addresses
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] SEQ_ADDR_0 = 13'h0000;
    localparam logic [ADDR_W-1:0] SEQ_ADDR_1 = 13'h1555;
    localparam logic [ADDR_W-1:0] SEQ_ADDR_2 = 13'h0AAA;
    localparam logic [ADDR_W-1:0] SEQ_ADDR_3 = 13'h1FFF;
    localparam logic [ADDR_W-1:0] SEQ_ADDR_4 = 13'h10F0;
    localparam logic [ADDR_W-1:0] SEQ_ADDR_STORE = 13'h0F0F;
    localparam logic [ADDR_W-1:0] SEQ_ADDR_RECALL = 13'h0F0E;
    localparam logic [STEP_W-1:0] SEQ_LAST_STEP = 3'h5;

    // ------------------------------------------------------------------
    // commands
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_READ = 3'h0,
        OP_WRITE = 3'h1,
        OP_SW_STORE = 3'h2,
        OP_SW_RECALL = 3'h3,
        OP_HW_STORE = 3'h4
    } nvc_op_e;

    // ------------------------------------------------------------------
    // timing, in ns, and derived clock counts (rounded up)
    // ------------------------------------------------------------------
    localparam int CLK_NS = 20;
    localparam int SYNC_CYCLES = 2;
    localparam int SELECT_TO_DATA_VALID_NS = 55;
    localparam int SEQUENCE_SELECT_PULSE_MIN_NS = 45;
    localparam int WRITE_PULSE_NS = 45;
    localparam int RECALL_NS = 20000;
    localparam int STORE_ASSERT_NS = 250;
    localparam int STORE_RECOVER_NS = 300;
    localparam int STORE_NS = 10000000;

    localparam logic [TMR_W-1:0] READ_CYCLES =
        TMR_W'((SELECT_TO_DATA_VALID_NS + CLK_NS - 1) / CLK_NS + SYNC_CYCLES);
    localparam logic [TMR_W-1:0] SEQ_PULSE_CYCLES =
        TMR_W'((SEQUENCE_SELECT_PULSE_MIN_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [TMR_W-1:0] WRITE_CYCLES = TMR_W'((WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [TMR_W-1:0] RECALL_CYCLES = TMR_W'((RECALL_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [TMR_W-1:0] ASSERT_CYCLES = TMR_W'((STORE_ASSERT_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [TMR_W-1:0] RECOVER_CYCLES =
        TMR_W'((STORE_RECOVER_NS + CLK_NS - 1) / CLK_NS + SYNC_CYCLES);
    localparam int STORE_CYCLES_DEF = (STORE_NS + CLK_NS - 1) / CLK_NS;

endpackage : nvc_pkg

// [verilog/nvc_timer.sv]
/*
 * Down counter used by the controller for every timed phase.
 * Assumes load and value come from logic on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none

module nvc_timer
    import nvc_pkg::*;
#(
    parameter logic [nvc_pkg::TMR_W-1:0] RESET_VAL = nvc_pkg::RECALL_CYCLES
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // control
    input wire logic load,
    input wire logic [nvc_pkg::TMR_W-1:0] load_val,
    // status
    output logic expired
);

    logic [TMR_W-1:0] cnt_r;
    logic [TMR_W-1:0] cnt_nxt;
    wire cnt_zero = (cnt_r == '0);

    assign cnt_nxt = load ? load_val : (cnt_zero ? cnt_r : cnt_r - TMR_W'(1));
    // a pending load masks a stale zero
    assign expired = cnt_zero && !load;

    always_ff @(posedge clk)
    begin
        if (!rstn)
            cnt_r <= RESET_VAL;
        else
            cnt_r <= cnt_nxt;
    end

endmodule : nvc_timer

`default_nettype wire
